/* File: design/tofrd_pkg.sv */
package tofrd_pkg;

	// ------------------------------------------------------------
	// field geometry and counts
	// ------------------------------------------------------------
	localparam int FULL_COLS = 8; // basic field columns
	localparam int FULL_PAIRS = 4; // row pairs, basic field
	localparam int BIN_COLS = 4; // binned field columns
	localparam int BIN_PAIRS = 2; // row pairs, binned field
	localparam int HDR_STEPS = 8; // integration times per hdr frame
	localparam int FIFO_DEPTH = 8; // words in the output buffer

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 12; // one converted pixel
	localparam int ACC_W = 18; // widest summed result
	localparam int WORD_W = 24; // output stream word
	localparam int LOW_NOISE_W = 18; // all-pixel sum
	localparam int FAST_BIN_W = 14; // 2x2 binned sum
	localparam int HIGH_DYN_W = 15; // 8-pixel sum per step

	// ------------------------------------------------------------
	// operating mode encodings on the mode input
	// ------------------------------------------------------------
	localparam logic [2:0] FULL_IMAGER_MODE = 3'h0;
	localparam logic [2:0] LOW_NOISE_RANGING_MODE = 3'h1;
	localparam logic [2:0] FAST_BINNED_RANGING_MODE = 3'h2;
	localparam logic [2:0] HIGH_DYNAMIC_RANGING_MODE = 3'h3;
	localparam logic [2:0] GRAY_FULL_IMAGER_MODE = 3'h4;
	localparam logic [2:0] GRAY_BINNED_IMAGER_MODE = 3'h5;

	// ------------------------------------------------------------
	// reserved sample codes and converter limits
	// ------------------------------------------------------------
	localparam logic [11:0] CODE_SAT = 12'h7ff; // saturated pixel
	localparam logic [11:0] CODE_OVF = 12'h7fe; // converter top
	localparam logic [11:0] CODE_UNF = 12'h800; // converter bottom
	localparam logic signed [12:0] DIFF_TOP = 13'sh07fd; // +2045
	localparam logic signed [12:0] DIFF_BOT = 13'sh1801; // -2047

	// ------------------------------------------------------------
	// summed-result word layout
	// ------------------------------------------------------------
	localparam int SUM_SAT_BIT = 23; // saturation flag
	localparam int SUM_OVF_BIT = 22; // converter overflow flag
	localparam int SUM_UNF_BIT = 21; // converter underflow flag
	localparam int SUM_IDX_LSB = 18; // hdr step index, 3 bits

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10; // 100 MHz
	localparam int INTEG_BASE_NS = 1000; // shortest integration
	localparam int INTEG_BASE_CYCLES = INTEG_BASE_NS / CLK_PERIOD_NS;

endpackage

/* File: design/tofrd_fifo.sv */
`timescale 1ns/1ps
module tofrd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic ce, // clock enable
	input wire logic in_valid, // write request
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // word written
	output logic out_valid, // word available
	input wire logic out_ready, // reader takes word
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// handshake terms
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && in_ready && ce;
	assign pop = out_valid && out_ready && ce;
	assign out_data = mem_r[rd_r];

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
		cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* File: design/tofrd_readout.sv */
// Behaviour
// - pixel value is gate A minus B, signed
// - each sample carries one saturation flag
// - two demodulation signals steer the gates
// - integrate first, then convert
// - 8x8 field, 2x2 binning gives 4x4
// - two rows at once, centre outward
// - columns left to right
// - sum saturated if any contributor saturated
// - limit flags, summed if any contributor
// - flags embedded in data, per mode
// - low-noise ranging sums 64 pixels, 18 bit
// - fast ranging sums 2x2 binned, 14 bit
// - hdr: 8 integrations, 8-pixel sums, 15 bit
// - gray full and gray binned imaging
// - reserved codes replace flagged samples
`timescale 1ns/1ps
module tofrd_readout #(
	parameter int INTEG_CYCLES = tofrd_pkg::INTEG_BASE_CYCLES,
	parameter int BUF_DEPTH = tofrd_pkg::FIFO_DEPTH
) (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic ce, // clock enable
	input wire logic start, // begin a frame, one cycle
	input wire logic [2:0] mode, // operating mode
	input wire logic embed_dis, // raw data, no reserved codes
	output logic busy, // frame in progress
	output logic frame_done, // frame finished, one cycle
	output logic demod_a, // steers storage_gate_a
	output logic demod_b, // steers storage_gate_b
	output logic cnv_req, // start a double-row conversion
	output logic [2:0] cnv_row_up, // upper-half row
	output logic [2:0] cnv_row_lo, // lower-half row
	output logic [2:0] cnv_col, // column
	output logic cnv_bin, // analog 2x2 binning on
	input wire logic cnv_done, // conversion result valid
	input wire logic [11:0] cnv_a_up, // gate A charge, upper
	input wire logic [11:0] cnv_b_up, // gate B charge, upper
	input wire logic cnv_sat_up, // saturation, upper
	input wire logic [11:0] cnv_a_lo, // gate A charge, lower
	input wire logic [11:0] cnv_b_lo, // gate B charge, lower
	input wire logic cnv_sat_lo, // saturation, lower
	output logic out_valid, // stream word available
	input wire logic out_ready, // stream word taken
	output logic [23:0] out_data // stream word
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_INTEG, ST_CONV, ST_WAIT, ST_DRAIN, ST_RESULT
	} tofrd_state_t;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// gate difference, clamp and flags: {sat, ovf, unf, value}
	function automatic logic [14:0] conv_pix(input logic [11:0] a,
		input logic [11:0] b, input logic sat);
		logic signed [12:0] d;
		logic ovf;
		logic unf;
		logic [11:0] v;
		d = $signed({1'b0, a}) - $signed({1'b0, b});
		ovf = d > tofrd_pkg::DIFF_TOP;
		unf = d < tofrd_pkg::DIFF_BOT;
		v = ovf ? tofrd_pkg::CODE_SAT : unf ? tofrd_pkg::CODE_UNF
			: d[11:0];
		return {sat, ovf, unf, v};
	endfunction

	// replace flagged samples by reserved codes unless disabled
	function automatic logic [11:0] embed(input logic [14:0] p,
		input logic dis);
		logic [11:0] r;
		r = p[11:0];
		if (!dis) begin
			if (p[14]) begin
				r = tofrd_pkg::CODE_SAT;
			end else if (p[13]) begin
				r = tofrd_pkg::CODE_OVF;
			end else if (p[12]) begin
				r = tofrd_pkg::CODE_UNF;
			end
		end
		return r;
	endfunction

	// sign-extend a sample to accumulator width
	function automatic logic signed [17:0] sext(input logic [14:0] p);
		return 18'(signed'(p[11:0]));
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tofrd_state_t state_r;
	logic [2:0] mode_r;
	logic embed_dis_r;
	logic [15:0] integ_cnt_r;
	logic [1:0] pair_r;
	logic [2:0] col_r;
	logic [2:0] hdr_r;
	logic [2:0] drain_r;
	logic [11:0] lo_mem_r [tofrd_pkg::FULL_COLS];
	logic [11:0] even_r;
	logic signed [17:0] acc_r;
	logic sat_acc_r;
	logic ovf_acc_r;
	logic unf_acc_r;
	logic demod_a_r;
	logic demod_b_r;
	logic frame_done_r;
	logic [2:0] last_col_r;

	logic is_bin;
	logic is_sum;
	logic is_hdr;
	logic [2:0] ncols;
	logic [1:0] npairs;
	logic [14:0] pu;
	logic [14:0] pl;
	logic add_up;
	logic add_lo;
	logic last_col;
	logic last_pair;
	logic push;
	logic [23:0] push_data;
	logic in_ready;
	logic [15:0] integ_len;
	logic signed [17:0] sum_nxt;

	// ------------------------------------------------------------
	// mode decode and geometry
	// ------------------------------------------------------------
	assign is_bin = (mode_r == tofrd_pkg::FAST_BINNED_RANGING_MODE) ||
		(mode_r == tofrd_pkg::GRAY_BINNED_IMAGER_MODE);
	assign is_hdr = (mode_r == tofrd_pkg::HIGH_DYNAMIC_RANGING_MODE);
	assign is_sum = is_hdr ||
		(mode_r == tofrd_pkg::LOW_NOISE_RANGING_MODE) ||
		(mode_r == tofrd_pkg::FAST_BINNED_RANGING_MODE);
	assign ncols = is_bin ? 3'(tofrd_pkg::BIN_COLS - 1)
		: 3'(tofrd_pkg::FULL_COLS - 1);
	assign npairs = is_bin ? 2'(tofrd_pkg::BIN_PAIRS - 1)
		: 2'(tofrd_pkg::FULL_PAIRS - 1);
	assign last_col = (col_r == ncols);
	assign last_pair = (pair_r == npairs);

	// converter addressing, centre rows first
	assign cnv_row_up = {1'b0, npairs} - {1'b0, pair_r};
	assign cnv_row_lo = {1'b0, npairs} + {1'b0, pair_r} + 3'h1;
	assign cnv_col = col_r;
	assign cnv_bin = is_bin;
	assign cnv_req = (state_r == ST_CONV) && in_ready && ce;

	// per-sample results
	assign pu = conv_pix(cnv_a_up, cnv_b_up, cnv_sat_up);
	assign pl = conv_pix(cnv_a_lo, cnv_b_lo, cnv_sat_lo);

	// integration length, doubled per hdr step
	assign integ_len = is_hdr ? 16'(INTEG_CYCLES) << hdr_r
		: 16'(INTEG_CYCLES);

	// which converted pixels join the running sum
	always_comb begin
		add_up = 1'b0;
		add_lo = 1'b0;
		if (mode_r == tofrd_pkg::LOW_NOISE_RANGING_MODE) begin
			add_up = 1'b1;
			add_lo = 1'b1;
		end else if (mode_r == tofrd_pkg::FAST_BINNED_RANGING_MODE) begin
			add_up = (col_r == 3'h1) || (col_r == 3'h2);
			add_lo = add_up;
		end else if (is_hdr) begin
			add_up = !hdr_r[0];
			add_lo = hdr_r[0];
		end
	end

	assign sum_nxt = acc_r + (add_up ? sext(pu) : 18'sh0)
		+ (add_lo ? sext(pl) : 18'sh0);

	// stream word to the buffer
	always_comb begin
		push = 1'b0;
		push_data = '0;
		if (state_r == ST_WAIT && cnv_done && !is_sum && col_r[0]) begin
			push = 1'b1;
			push_data = {even_r, embed(pu, embed_dis_r)};
		end else if (state_r == ST_DRAIN && drain_r[0]) begin
			push = in_ready;
			push_data = {lo_mem_r[drain_r - 3'h1], lo_mem_r[drain_r]};
		end else if (state_r == ST_RESULT) begin
			push = in_ready;
			push_data[17:0] = acc_r;
			push_data[tofrd_pkg::SUM_SAT_BIT] = sat_acc_r;
			push_data[tofrd_pkg::SUM_OVF_BIT] = ovf_acc_r;
			push_data[tofrd_pkg::SUM_UNF_BIT] = unf_acc_r;
			push_data[tofrd_pkg::SUM_IDX_LSB +: 3] = hdr_r;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------

	// frame, integration, conversion and drain steps
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			mode_r <= 3'h0;
			embed_dis_r <= 1'b0;
			integ_cnt_r <= 16'h0;
			pair_r <= 2'h0;
			col_r <= 3'h0;
			hdr_r <= 3'h0;
			drain_r <= 3'h0;
			frame_done_r <= 1'b0;
		end else if (ce) begin
			frame_done_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (start) begin
					mode_r <= mode;
					embed_dis_r <= embed_dis;
					hdr_r <= 3'h0;
					integ_cnt_r <= 16'h0;
					state_r <= ST_INTEG;
				end
			end
			ST_INTEG: begin
				if (integ_cnt_r == integ_len) begin
					integ_cnt_r <= 16'h0;
					pair_r <= is_hdr ? hdr_r[2:1] : 2'h0;
					col_r <= 3'h0;
					state_r <= ST_CONV;
				end else begin
					integ_cnt_r <= integ_cnt_r + 16'h1;
				end
			end
			ST_CONV: begin
				if (in_ready) begin
					state_r <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cnv_done) begin
					col_r <= col_r + 3'h1;
					if (!last_col) begin
						state_r <= ST_CONV;
					end else if (!is_sum) begin
						drain_r <= 3'h0;
						state_r <= ST_DRAIN;
					end else if (last_pair || is_hdr ||
						mode_r == tofrd_pkg::FAST_BINNED_RANGING_MODE) begin
						state_r <= ST_RESULT;
					end else begin
						col_r <= 3'h0;
						pair_r <= pair_r + 2'h1;
						state_r <= ST_CONV;
					end
				end
			end
			ST_DRAIN: begin
				if (!drain_r[0] || in_ready) begin
					drain_r <= drain_r + 3'h1;
					if (drain_r == ncols) begin
						col_r <= 3'h0;
						pair_r <= pair_r + 2'h1;
						state_r <= last_pair ? ST_IDLE : ST_CONV;
						frame_done_r <= last_pair;
					end
				end
			end
			ST_RESULT: begin
				if (in_ready) begin
					if (is_hdr && hdr_r != 3'(tofrd_pkg::HDR_STEPS - 1))
					begin
						hdr_r <= hdr_r + 3'h1;
						state_r <= ST_INTEG;
					end else begin
						state_r <= ST_IDLE;
						frame_done_r <= 1'b1;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// sample handling
	// ------------------------------------------------------------

	// lower-row samples wait until the upper row is out
	always_ff @(posedge clk) begin
		if (ce && state_r == ST_WAIT && cnv_done && !is_sum) begin
			lo_mem_r[col_r] <= embed(pl, embed_dis_r);
		end
	end

	// even column of the upper row waits for its odd partner
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			even_r <= 12'h0;
		end else if (ce && state_r == ST_WAIT && cnv_done && !col_r[0])
		begin
			even_r <= embed(pu, embed_dis_r);
		end
	end

	// running sum and contributor flags
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_r <= 18'sh0;
			sat_acc_r <= 1'b0;
			ovf_acc_r <= 1'b0;
			unf_acc_r <= 1'b0;
		end else if (ce) begin
			if (state_r == ST_INTEG) begin
				acc_r <= 18'sh0;
				sat_acc_r <= 1'b0;
				ovf_acc_r <= 1'b0;
				unf_acc_r <= 1'b0;
			end else if (state_r == ST_WAIT && cnv_done && is_sum) begin
				acc_r <= sum_nxt;
				sat_acc_r <= sat_acc_r | (add_up & pu[14])
					| (add_lo & pl[14]);
				ovf_acc_r <= ovf_acc_r | (add_up & pu[13])
					| (add_lo & pl[13]);
				unf_acc_r <= unf_acc_r | (add_up & pu[12])
					| (add_lo & pl[12]);
			end
		end
	end

	// demodulation signals alternate during integration only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			demod_a_r <= 1'b0;
			demod_b_r <= 1'b0;
		end else if (ce) begin
			if (state_r == ST_INTEG && integ_cnt_r != integ_len) begin
				demod_a_r <= ~demod_a_r;
				demod_b_r <= demod_a_r;
			end else begin
				demod_a_r <= 1'b0;
				demod_b_r <= 1'b0;
			end
		end
	end

	// last requested column, watched by the order check
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			last_col_r <= 3'h0;
		end else if (cnv_req) begin
			last_col_r <= col_r;
		end
	end

	assign demod_a = demod_a_r;
	assign demod_b = demod_b_r;
	assign busy = (state_r != ST_IDLE);
	assign frame_done = frame_done_r;

	// ------------------------------------------------------------
	// output buffer
	// ------------------------------------------------------------
	tofrd_fifo #(
		.WIDTH(tofrd_pkg::WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.in_valid(push),
		.in_ready(in_ready),
		.in_data(push_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	demod_excl_a: assert property (@(posedge clk) disable iff (reset)
		!(demod_a && demod_b)) else $error("both gates steered");
	demod_phase_a: assert property (@(posedge clk) disable iff (reset)
		cnv_req |-> !demod_a && !demod_b) else $error("demod in readout");
	col_order_a: assert property (@(posedge clk) disable iff (reset)
		cnv_req && cnv_col != 3'h0 |-> cnv_col == last_col_r + 3'h1)
		else $error("column order broken");
	centre_start_a: assert property (@(posedge clk) disable iff (reset)
		cnv_req && !cnv_bin && pair_r == 2'h0 |->
		cnv_row_up == 3'h3 && cnv_row_lo == 3'h4)
		else $error("readout not from centre");
	row_pair_a: assert property (@(posedge clk) disable iff (reset)
		cnv_req |-> cnv_row_up + cnv_row_lo == (cnv_bin ? 3'h3 : 3'h7))
		else $error("rows not symmetric");
	bin_field_a: assert property (@(posedge clk) disable iff (reset)
		cnv_req && cnv_bin |-> cnv_col < 3'h4 && cnv_row_lo < 3'h4)
		else $error("binned address out of field");
	sat_code_a: assert property (@(posedge clk) disable iff (reset)
		ce && state_r == ST_WAIT && cnv_done && !is_sum && cnv_sat_lo
		&& !embed_dis_r |=> lo_mem_r[$past(col_r)] == 12'h7ff)
		else $error("saturation code missing");
	sum_sat_a: assert property (@(posedge clk) disable iff (reset)
		ce && state_r == ST_WAIT && cnv_done && is_sum && add_up
		&& cnv_sat_up |=> sat_acc_r) else $error("sum saturation lost");
	frame_end_a: assert property (@(posedge clk) disable iff (reset)
		frame_done |-> state_r == ST_IDLE) else $error("done while busy");
endmodule

/* File: sim/tofrd_conv_model.sv */
`timescale 1ns/1ps
module tofrd_conv_model (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic cnv_req, // conversion request
	input wire logic [2:0] row_up, // upper row address
	input wire logic [2:0] row_lo, // lower row address
	input wire logic [2:0] col, // column address
	input wire logic [31:0] lat, // extra wait cycles
	input wire logic pat, // 1 = limit pattern
	output logic cnv_done, // result strobe
	output logic [11:0] a_up, // gate A charge, upper
	output logic [11:0] b_up, // gate B charge, upper
	output logic sat_up, // saturation, upper
	output logic [11:0] a_lo, // gate A charge, lower
	output logic [11:0] b_lo, // gate B charge, lower
	output logic sat_lo // saturation, lower
);
	logic busy_r;
	int cnt_r;
	logic [2:0] ru_r, rl_r, c_r;

	// ------------------------------------------------------------
	// pixel charges
	// ------------------------------------------------------------
	// limit pattern per column: sat, top, bottom, edge values
	function automatic logic [24:0] pix(input logic [2:0] r,
		input logic [2:0] c, input logic p);
		logic [11:0] a;
		a = 12'h100 + 12'({r, c}) * 12'h005;
		if (p && c == 3'h0) return {1'b1, a, 12'h196};
		if (p && c == 3'h1) return {1'b0, 12'hfff, 12'h000};
		if (p && c == 3'h2) return {1'b0, 12'h000, 12'hfff};
		if (p && c == 3'h3) return {1'b0, 12'h7fd, 12'h000};
		if (p && c == 3'h4) return {1'b0, 12'h000, 12'h7ff};
		return {1'b0, a, 12'h196};
	endfunction

	// ------------------------------------------------------------
	// request, wait, answer
	// ------------------------------------------------------------
	// lines go to the inverse once the strobe is gone
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
			cnt_r <= 0;
			cnv_done <= 1'b0;
			{ru_r, rl_r, c_r} <= 9'h000;
			{sat_up, a_up, b_up} <= 25'h0000000;
			{sat_lo, a_lo, b_lo} <= 25'h0000000;
		end else begin
			cnv_done <= 1'b0;
			if (cnv_done) begin
				{sat_up, a_up, b_up} <= ~{sat_up, a_up, b_up};
				{sat_lo, a_lo, b_lo} <= ~{sat_lo, a_lo, b_lo};
			end
			if (!busy_r && cnv_req) begin
				busy_r <= 1'b1;
				cnt_r <= lat;
				{ru_r, rl_r, c_r} <= {row_up, row_lo, col};
			end else if (busy_r && cnt_r != 0) begin
				cnt_r <= cnt_r - 1;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				cnv_done <= 1'b1;
				{sat_up, a_up, b_up} <= pix(ru_r, c_r, pat);
				{sat_lo, a_lo, b_lo} <= pix(rl_r, c_r, pat);
			end
		end
	end
endmodule

/* File: sim/tofrd_readout_bench.sv */
`timescale 1ns/1ps
module tofrd_readout_bench;
	logic clk, reset, ce, start, embed_dis, out_ready, pat;
	logic [2:0] mode;
	logic busy, frame_done, demod_a, demod_b, cnv_req, cnv_bin, cnv_done;
	logic [2:0] row_up, row_lo, col;
	logic [11:0] a_up, b_up, a_lo, b_lo;
	logic sat_up, sat_lo, out_valid;
	logic [23:0] out_data;
	logic [23:0] got[$], exp_q[$];
	int lat = 0, stall = 0, cycles = 0, reqs = 0;
	int err_count = 0, samples_checked = 0;

	tofrd_readout #(.INTEG_CYCLES(4), .BUF_DEPTH(8)) u_dut (.clk(clk),
		.reset(reset), .ce(ce), .start(start), .mode(mode),
		.embed_dis(embed_dis), .busy(busy), .frame_done(frame_done),
		.demod_a(demod_a), .demod_b(demod_b), .cnv_req(cnv_req),
		.cnv_row_up(row_up), .cnv_row_lo(row_lo), .cnv_col(col),
		.cnv_bin(cnv_bin), .cnv_done(cnv_done), .cnv_a_up(a_up),
		.cnv_b_up(b_up), .cnv_sat_up(sat_up), .cnv_a_lo(a_lo),
		.cnv_b_lo(b_lo), .cnv_sat_lo(sat_lo), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));

	tofrd_conv_model u_conv (.clk(clk), .reset(reset), .cnv_req(cnv_req),
		.row_up(row_up), .row_lo(row_lo), .col(col), .lat(lat), .pat(pat),
		.cnv_done(cnv_done), .a_up(a_up), .b_up(b_up), .sat_up(sat_up),
		.a_lo(a_lo), .b_lo(b_lo), .sat_lo(sat_lo));

	// ------------------------------------------------------------
	// clock, timeout, consumer, monitors
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// consumer: always, every fourth cycle, or never ready
	always @(posedge clk) begin
		cycles++;
		if (cnv_req === 1'b1) reqs++;
		if (out_valid === 1'b1 && out_ready === 1'b1 && ce === 1'b1)
			got.push_back(out_data);
		if (cycles == 60000) begin
			chk(24'(cycles), 24'h0);
			results();
		end
		if ((demod_a | demod_b | cnv_req) === 1'b1)
			chk({22'h0, demod_a & demod_b, cnv_req & (demod_a | demod_b)},
				24'h0);
		#1 out_ready = stall == 0 || (stall == 1 && cycles % 4 == 0);
	end

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask

	// ------------------------------------------------------------
	// expected values
	// ------------------------------------------------------------
	function automatic logic [11:0] ev(input int r, input int c,
		input logic p, input logic raw);
		int d;
		d = (r * 8 + c) * 5 - 150;
		if (p && c == 1) d = 4095;
		if (p && c == 2) d = -4095;
		if (p && c == 3) d = 2045;
		if (p && c == 4) d = -2047;
		if (p && c == 0 && !raw) return 12'h7ff;
		if (d > 2045) return raw ? 12'h7ff : 12'h7fe;
		if (d < -2047) return 12'h800;
		return 12'(d);
	endfunction

	// centre pair first, upper row then lower row
	task automatic exp_img(input int n, input logic p, input logic raw);
		int r;
		exp_q.delete();
		for (int k = 0; k < n; k++) begin
			r = k[0] ? n / 2 + k / 2 : n / 2 - 1 - k / 2;
			for (int c = 0; c < n; c += 2)
				exp_q.push_back({ev(r, c, p, raw), ev(r, c + 1, p, raw)});
		end
	endtask

	task automatic exp_sum(input int r0, input int r1, input int c0,
		input int c1, input int k);
		int s;
		s = 0;
		for (int r = r0; r <= r1; r++)
			for (int c = c0; c <= c1; c++)
				s += (r * 8 + c) * 5 - 150;
		exp_q.push_back({3'h0, 3'(k), 18'(s)});
	endtask

	// ------------------------------------------------------------
	// frame control
	// ------------------------------------------------------------
	task automatic kick(input logic [2:0] m, input logic dis);
		got.delete();
		mode = m;
		embed_dis = dis;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask

	task automatic finish_frame();
		int n;
		n = 0;
		while (frame_done !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
		if (n == 20000) begin
			chk(24'(n), 24'h0);
			results();
		end
		n = 0;
		while (out_valid !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		tick(2);
	endtask

	task automatic cmp_all();
		chk(24'(got.size()), 24'(exp_q.size()));
		foreach (exp_q[i])
			chk(i < got.size() ? got[i] : 24'hxxxxxx, exp_q[i]);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_full();
		logic [2:0] ms[4] = '{3'h0, 3'h4, 3'h6, 3'h7};
		foreach (ms[i]) begin
			exp_img(8, 1'b0, 1'b0);
			kick(ms[i], 1'b0);
			finish_frame();
			cmp_all();
		end
		$display("test full imager finished");
	endtask

	task automatic t_limits();
		pat = 1'b1;
		lat = 3;
		stall = 1;
		for (int raw = 0; raw < 2; raw++) begin
			exp_img(8, 1'b1, raw[0]);
			kick(3'h0, raw[0]);
			finish_frame();
			cmp_all();
		end
		kick(3'h1, 1'b0);
		finish_frame();
		chk({21'h0, got[0][23:21]}, 24'h000007);
		pat = 1'b0;
		lat = 0;
		stall = 0;
		$display("test limit codes finished");
	endtask

	task automatic t_binned();
		lat = 1;
		exp_img(4, 1'b0, 1'b0);
		kick(3'h5, 1'b0);
		tick(12);
		chk({23'h0, cnv_bin}, 24'h000001);
		finish_frame();
		cmp_all();
		lat = 0;
		$display("test binned imager finished");
	endtask

	task automatic t_sums();
		exp_q.delete();
		exp_sum(0, 7, 0, 7, 0);
		kick(3'h1, 1'b0);
		finish_frame();
		cmp_all();
		exp_q.delete();
		exp_sum(1, 2, 1, 2, 0);
		kick(3'h2, 1'b0);
		finish_frame();
		cmp_all();
		exp_q.delete();
		for (int k = 0; k < 8; k++) begin
			if (k[0]) exp_sum(4 + k / 2, 4 + k / 2, 0, 7, k);
			else exp_sum(3 - k / 2, 3 - k / 2, 0, 7, k);
		end
		kick(3'h3, 1'b0);
		finish_frame();
		cmp_all();
		$display("test summing modes finished");
	endtask

	// consumer never ready: buffer fills, requests stop, start ignored
	task automatic t_full_buffer();
		int r;
		stall = 2;
		exp_img(8, 1'b0, 1'b0);
		kick(3'h0, 1'b0);
		tick(150);
		r = reqs;
		start = 1'b1;
		mode = 3'h1;
		tick(1);
		start = 1'b0;
		tick(60);
		chk(24'(reqs), 24'(r));
		chk({23'h0, busy}, 24'h000001);
		stall = 0;
		finish_frame();
		cmp_all();
		$display("test full buffer finished");
	endtask

	task automatic t_freeze();
		logic [1:0] d;
		exp_img(8, 1'b0, 1'b0);
		kick(3'h0, 1'b0);
		tick(2);
		ce = 1'b0;
		tick(1);
		d = {demod_a, demod_b};
		chk({22'h0, d}, 24'h000001);
		for (int i = 0; i < 6; i++) begin
			tick(1);
			chk({22'h0, demod_a, demod_b}, {22'h0, d});
		end
		ce = 1'b1;
		finish_frame();
		cmp_all();
		$display("test clock enable finished");
	endtask

	task automatic t_reset_mid();
		kick(3'h0, 1'b0);
		tick(40);
		reset = 1'b1;
		#1;
		chk({busy, frame_done, cnv_req, out_valid}, 24'h0);
		tick(2);
		reset = 1'b0;
		exp_q.delete();
		exp_sum(1, 2, 1, 2, 0);
		kick(3'h2, 1'b0);
		finish_frame();
		cmp_all();
		$display("test reset mid-frame finished");
	endtask

	task automatic results();
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		start = 1'b0;
		mode = 3'h0;
		embed_dis = 1'b0;
		pat = 1'b0;
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		t_full();
		t_limits();
		t_binned();
		t_sums();
		t_full_buffer();
		t_freeze();
		t_reset_mid();
		results();
	end
endmodule
